// File: design/ifd_input_function_decoder.sv
`timescale 1ns/1ps
// How it works
// - Bit 11 enables proximity-qualified homing
// - Home input ignored until proximity flag set
// - Bit 10 enables encoder, else unused
// - Bits 5:3 select input 2 function
// - Bits 2:0 select input 1 function
// - Selector zero is report-only general input
// - Selectors one, two are CW, CCW limits
// - Selector three without encoder starts indexed move
// - Selector three with encoder captures on any edge, rising edge starts only while index pending
// - Selector four stops jog/registration move, decelerated
// - Selector four with encoder captures at stop
// - Selector five rising edge halts all motion immediately
// - Selector six is the home sensor
// - Selector seven flags configuration error
// - Duplicate non-general functions flag configuration error
module ifd_input_function_decoder #(
    parameter int POS_W = ifd_pkg::POS_WIDTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Configuration word write
    input wire logic cfgWrite,
    input wire logic [15:0] cfgData,
    output logic [15:0] cfgWord,
    output logic cfgError,
    // Polarity from second configuration word, 1 means active high
    input wire logic [1:0] inActiveLevel,
    // Discrete inputs
    input wire logic [1:0] inPin,
    output logic [1:0] inStatus,
    // Homing and motion context
    input wire logic proximityFlag,
    input wire logic homingActive,
    input wire logic jogRegActive,
    input wire logic indexPending,
    // Encoder
    input wire logic [POS_W-1:0] encoderPos,
    output logic encoderEnabled,
    output logic [POS_W-1:0] capturedPos,
    output logic captureValid,
    // Motion requests
    output ifd_pkg::ifd_motion_t motion
);
    import ifd_pkg::*;

    ////////////////////////////////////////////////////////////////////
    logic [1:0] syncA;
    logic [1:0] syncB;
    logic [1:0] activePrev;
    logic [1:0] active;
    logic [1:0] rawActive;
    logic [1:0] warmUp;
    logic [1:0] rise;
    logic [1:0] anyEdge;
    logic [SEL_WIDTH-1:0] sel [NUM_INPUTS];
    logic encEn;
    logic proxEn;
    logic proxSeen;
    logic next_cfgError;
    logic captureHit;
    ifd_motion_t next_motion;

    // Configuration register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfgWord <= CFG_RESET;
        end else if (cfgWrite) begin
            cfgWord <= cfgData;
        end
    end

    assign sel[1] = cfgWord[IN2_SEL_LSB +: SEL_WIDTH];
    assign sel[0] = cfgWord[IN1_SEL_LSB +: SEL_WIDTH];
    assign encEn = cfgWord[ENC_EN_BIT];
    assign proxEn = cfgWord[PROX_EN_BIT];
    assign encoderEnabled = encEn;

    // Error checks on selector fields
    always_comb begin
        next_cfgError = 1'b0;
        for (int i = 0; i < NUM_INPUTS; i++) begin
            if (sel[i] == SEL_WIDTH'(FN_INVALID)) begin
                next_cfgError = 1'b1;
            end
        end
        if (sel[0] == sel[1] && sel[0] != SEL_WIDTH'(FN_GENERAL)) begin
            next_cfgError = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfgError <= 1'b0;
        end else begin
            cfgError <= next_cfgError;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Input synchroniser and polarity
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            syncA <= 2'h0;
            syncB <= 2'h0;
            activePrev <= 2'h0;
            warmUp <= 2'h0;
        end else begin
            syncA <= inPin;
            syncB <= syncA;
            activePrev <= active;
            warmUp <= {warmUp[0], 1'b1};
        end
    end

    // Inputs read inactive until syncB holds a real pin sample
    assign rawActive = ~(syncB ^ inActiveLevel);
    assign active = rawActive & {2{warmUp[1]}};
    assign rise = active & ~activePrev;
    assign anyEdge = active ^ activePrev;

    // Report-only status for all inputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            inStatus <= 2'h0;
        end else begin
            inStatus <= active;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Proximity qualification, rearmed each homing run
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            proxSeen <= 1'b0;
        end else if (!homingActive) begin
            proxSeen <= 1'b0;
        end else if (proximityFlag) begin
            proxSeen <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Function dispatch
    always_comb begin
        next_motion = '0;
        captureHit = 1'b0;
        for (int i = 0; i < NUM_INPUTS; i++) begin
            case (sel[i])
                SEL_WIDTH'(FN_GENERAL): begin
                end
                SEL_WIDTH'(FN_CLOCKWISE_END_LIMIT): begin
                    next_motion.cwLimit |= active[i];
                end
                SEL_WIDTH'(FN_COUNTERCLOCKWISE_END_LIMIT): begin
                    next_motion.ccwLimit |= active[i];
                end
                SEL_WIDTH'(FN_START_INDEX): begin
                    if (encEn) begin
                        captureHit |= anyEdge[i];
                        next_motion.startIndexed |= rise[i] & indexPending;
                    end else begin
                        next_motion.startIndexed |= rise[i];
                    end
                end
                SEL_WIDTH'(FN_STOP_JOG): begin
                    next_motion.stopJog |= rise[i] & jogRegActive;
                    captureHit |= encEn & rise[i] & jogRegActive;
                end
                SEL_WIDTH'(FN_ESTOP): begin
                    next_motion.estop |= rise[i];
                end
                SEL_WIDTH'(FN_HOME): begin
                    if (!proxEn || proxSeen) begin
                        next_motion.homeEdge |= rise[i];
                        next_motion.homeLevel |= active[i];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            motion <= '0;
        end else begin
            motion <= next_motion;
        end
    end

    // Encoder capture
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            capturedPos <= '0;
            captureValid <= 1'b0;
        end else begin
            captureValid <= captureHit;
            if (captureHit) begin
                capturedPos <= encoderPos;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    property p_dup_error;
        @(posedge clk) disable iff (!rst_b)
        (cfgWord[2:0] == cfgWord[5:3] && cfgWord[2:0] != 3'h0) |=> cfgError;
    endproperty
    a_dup_error: assert property (p_dup_error) else $error("duplicate selector not flagged");

    property p_inv_error;
        @(posedge clk) disable iff (!rst_b)
        (cfgWord[2:0] == 3'h7 || cfgWord[5:3] == 3'h7) |=> cfgError;
    endproperty
    a_inv_error: assert property (p_inv_error) else $error("invalid selector not flagged");

    property p_prox_block;
        @(posedge clk) disable iff (!rst_b)
        (proxEn && !proxSeen) |=> !motion.homeEdge && !motion.homeLevel;
    endproperty
    a_prox_block: assert property (p_prox_block) else $error("home seen before proximity");

    property p_estop;
        @(posedge clk) disable iff (!rst_b)
        (cfgWord[2:0] == 3'h5 && rise[0]) |=> motion.estop;
    endproperty
    a_estop: assert property (p_estop) else $error("estop not raised");

    property p_start_noenc;
        @(posedge clk) disable iff (!rst_b)
        (!encEn && cfgWord[2:0] == 3'h3 && rise[0]) |=> motion.startIndexed;
    endproperty
    a_start_noenc: assert property (p_start_noenc) else $error("start not raised");

    property p_capture;
        @(posedge clk) disable iff (!rst_b)
        (encEn && cfgWord[2:0] == 3'h3 && anyEdge[0]) |=>
            captureValid && capturedPos == $past(encoderPos);
    endproperty
    a_capture: assert property (p_capture) else $error("encoder not captured");

    property p_general;
        @(posedge clk) disable iff (!rst_b)
        (cfgWord[5:0] == 6'h00) |=> motion == '0;
    endproperty
    a_general: assert property (p_general) else $error("general input moved axis");

    property p_stop_jog;
        @(posedge clk) disable iff (!rst_b)
        (cfgWord[2:0] == 3'h4 && rise[0] && jogRegActive) |=> motion.stopJog;
    endproperty
    a_stop_jog: assert property (p_stop_jog) else $error("jog stop not raised");

    property p_sync_edge;
        @(posedge clk) disable iff (!rst_b)
        rise[0] |-> (syncB[0] == inActiveLevel[0]) && !activePrev[0];
    endproperty
    a_sync_edge: assert property (p_sync_edge) else $error("edge without polarity match");

endmodule : ifd_input_function_decoder

// File: design/ifd_pkg.sv
package ifd_pkg;

    localparam int CFG_WIDTH = 16;
    localparam int SEL_WIDTH = 3;
    localparam int IN1_SEL_LSB = 0;
    localparam int IN2_SEL_LSB = 3;
    localparam int RSV_LO_LSB = 6;
    localparam int RSV_LO_MSB = 9;
    localparam int ENC_EN_BIT = 10;
    localparam int PROX_EN_BIT = 11;
    localparam int RSV_HI_BIT = 12;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam int POS_WIDTH = 32;
    localparam int NUM_INPUTS = 2;

    typedef enum logic [2:0] {
        FN_GENERAL,
        FN_CLOCKWISE_END_LIMIT,
        FN_COUNTERCLOCKWISE_END_LIMIT,
        FN_START_INDEX,
        FN_STOP_JOG,
        FN_ESTOP,
        FN_HOME,
        FN_INVALID
    } ifd_func_t;

    typedef struct packed {
        logic cwLimit;
        logic ccwLimit;
        logic startIndexed;
        logic stopJog;
        logic estop;
        logic homeEdge;
        logic homeLevel;
    } ifd_motion_t;

endpackage : ifd_pkg

// File: tb/ifd_host_model.sv
`timescale 1ns/1ps
module ifd_host_model (
    // Clock
    input wire logic clk,
    // Configuration service
    output logic cfgWrite,
    output logic [15:0] cfgData
);
    import ifd_pkg::*;
    initial begin
        cfgWrite = 1'b0;
        cfgData = 16'h0000;
    end
    ////////////////////////////////////////
    // Raw writes may break the field rules
    task automatic writeCfg(input logic [15:0] w, input bit raw);
        if (!raw && w[2:0] == 3'h7) w[2:0] = 3'h0;
        if (!raw && w[5:3] == 3'h7) w[5:3] = 3'h0;
        @(negedge clk);
        cfgData = raw ? w : (w & 16'h0C3F);
        cfgWrite = 1'b1;
        @(negedge clk);
        cfgWrite = 1'b0;
        cfgData = ~cfgData;
        repeat (2) @(negedge clk);
    endtask : writeCfg
endmodule : ifd_host_model

// File: tb/input_function_config_decoder_test.sv
`timescale 1ns/1ps
module input_function_config_decoder_test;
    import ifd_pkg::*;
    logic clk, rst_b, cfgWrite, cfgError, proximityFlag, homingActive;
    logic jogRegActive, indexPending, encoderEnabled, captureValid;
    logic [15:0] cfgData, cfgWord;
    logic [1:0] inActiveLevel, inPin, inStatus;
    logic [31:0] encoderPos, capturedPos;
    ifd_motion_t motion, seen;
    int error_cnt = 0, n_checks = 0, pulses, caps;
    logic [15:0] errWord [4] = '{16'h0007, 16'h0038, 16'h0009, 16'h0031};
    logic errExp [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    logic [6:0] fnMask [7] = '{7'h00, 7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h03};

    ifd_host_model ifd_host_model_inst (.clk(clk), .cfgWrite(cfgWrite), .cfgData(cfgData));
    ifd_input_function_decoder ifd_input_function_decoder_inst (
        .clk(clk), .rst_b(rst_b), .cfgWrite(cfgWrite), .cfgData(cfgData),
        .cfgWord(cfgWord), .cfgError(cfgError), .inActiveLevel(inActiveLevel),
        .inPin(inPin), .inStatus(inStatus), .proximityFlag(proximityFlag),
        .homingActive(homingActive), .jogRegActive(jogRegActive),
        .indexPending(indexPending), .encoderPos(encoderPos),
        .encoderEnabled(encoderEnabled), .capturedPos(capturedPos),
        .captureValid(captureValid), .motion(motion));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    // Move pins, gather outputs over six cycles
    task automatic pin(input logic [1:0] v);
        @(negedge clk);
        inPin = v;
        seen = '0;
        pulses = 0;
        caps = 0;
        repeat (6) begin
            @(negedge clk);
            seen = seen | motion;
            pulses += motion.estop + motion.startIndexed + motion.stopJog + motion.homeEdge;
            caps += captureValid;
        end
    endtask : pin

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    initial begin
        #50000;
        error_cnt++;
        end_sim;
    end
    ////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        inActiveLevel = 2'b11;
        inPin = 2'b00;
        proximityFlag = 1'b0;
        homingActive = 1'b0;
        jogRegActive = 1'b1;
        indexPending = 1'b1;
        encoderPos = 32'h1234ABCD;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        check(cfgWord, 16'h0000);
        check(motion, 7'h00);
        ifd_host_model_inst.writeCfg(16'h000D, 1'b0);
        check(cfgWord, 16'h000D);
        pin(2'b01);
        check(seen.estop, 1'b1);
        check(pulses, 1);
        pin(2'b11);
        check(motion.cwLimit, 1'b1);
        check(inStatus, 2'b11);
        pin(2'b00);
        inActiveLevel = 2'b01;
        ifd_host_model_inst.writeCfg(16'h0010, 1'b0);
        pin(2'b00);
        check(motion.ccwLimit, 1'b1);
        check(inStatus, 2'b10);
        inActiveLevel = 2'b11;
        $display("test polarity done");
        for (int k = 0; k < 4; k++) begin
            ifd_host_model_inst.writeCfg(errWord[k], 1'b1);
            check(cfgError, errExp[k]);
        end
        homingActive = 1'b1;
        for (int s = 0; s < 7; s++) begin
            ifd_host_model_inst.writeCfg(16'(s), 1'b0);
            check(cfgError, 1'b0);
            pin(2'b01);
            check(seen, fnMask[s]);
            check(caps, 0);
            pin(2'b00);
        end
        $display("test selectors done");
        ifd_host_model_inst.writeCfg(16'h0403, 1'b0);
        check(encoderEnabled, 1'b1);
        pin(2'b01);
        check(seen.startIndexed, 1'b1);
        check(caps, 1);
        check(capturedPos, 32'h1234ABCD);
        encoderPos = 32'h0000BEEF;
        pin(2'b00);
        check(caps, 1);
        check(capturedPos, 32'h0000BEEF);
        indexPending = 1'b0;
        pin(2'b01);
        check(seen.startIndexed, 1'b0);
        check(caps, 1);
        pin(2'b00);
        indexPending = 1'b1;
        encoderPos = 32'h00C0FFEE;
        ifd_host_model_inst.writeCfg(16'h0404, 1'b0);
        jogRegActive = 1'b0;
        pin(2'b01);
        check(seen.stopJog, 1'b0);
        check(caps, 0);
        pin(2'b00);
        jogRegActive = 1'b1;
        pin(2'b01);
        check(seen.stopJog, 1'b1);
        check(caps, 1);
        check(capturedPos, 32'h00C0FFEE);
        pin(2'b00);
        $display("test encoder done");
        ifd_host_model_inst.writeCfg(16'h0806, 1'b0);
        pin(2'b01);
        check(seen.homeEdge, 1'b0);
        pin(2'b00);
        proximityFlag = 1'b1;
        pin(2'b01);
        check(seen.homeEdge, 1'b1);
        $display("test homing done");
        // Active-low inputs idle high across a mid-run reset
        rst_b = 1'b0;
        inActiveLevel = 2'b00;
        inPin = 2'b11;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        ifd_host_model_inst.writeCfg(16'h0403, 1'b0);
        check(capturedPos, 32'h00000000);
        check(motion, 7'h00);
        check(inStatus, 2'b00);
        $display("test reset done");
        end_sim;
    end
endmodule : input_function_config_decoder_test
